// ==== verilog/hbp_pkg.sv ====
// Purpose: Shared constants for the host bus, DMA and interrupt port.
// Assumes: One 20 MHz clock, synchronous active-high reset.
// Notes:   Pin inputs travel as one packed vector through the synchroniser.
package hbp_pkg;

    localparam int ADDR_W = 8;                       // Register address width.
    localparam int DATA_W = 16;                      // Data bus width.

    // Positions inside the synchronised pin vector.
    localparam int P_ADDR = 0;
    localparam int P_DATA = 8;
    localparam int P_CS   = 24;
    localparam int P_RD   = 25;
    localparam int P_WR   = 26;
    localparam int P_ALE  = 27;
    localparam int P_BHE  = 28;
    localparam int P_BLE  = 29;
    localparam int P_DIR  = 30;
    localparam int P_DS   = 31;
    localparam int P_TRANSMIT_MESSAGE_END = 32;
    localparam int PIN_W  = 33;

    // Internal access time before read data is placed on the pins.
    localparam int CLK_NS     = 50;
    localparam int ACCESS_NS  = 100;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;

    // Device register addresses that this port reacts to.
    localparam logic [7:0] INT_VECTOR_ADDR  = 8'h00;
    localparam logic [7:0] LINK_RX_FIFO_ADDR = 8'h40;
    localparam logic [7:0] LINK_TX_FIFO_ADDR = 8'h42;
    localparam logic [7:0] LINK_STATUS_ADDR  = 8'h44;

    // Byte lane codes: bit 1 is the upper lane, bit 0 the lower lane.
    localparam logic [1:0] LANE_NONE = 2'h0;
    localparam logic [1:0] LANE_LOW  = 2'h1;
    localparam logic [1:0] LANE_HIGH = 2'h2;
    localparam logic [1:0] LANE_WORD = 2'h3;

    // Receive status byte layout.
    localparam int STAT_MODE_LSB = 6;
    localparam int STAT_ZERO_BIT = 5;
    localparam int STAT_CODE_W   = 5;

    // Reset values.
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [7:0]  ADDR_RST = 8'h00;
    localparam logic [PIN_W-1:0] PIN_RST = 33'h1ffffffff;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_READ_WAIT,
        BUS_READ_DRIVE,
        BUS_WRITE_HOLD
    } hbp_bus_state_e;

endpackage : hbp_pkg

// ==== verilog/hbp_pin_sync.sv ====
// Purpose: Three-stage synchroniser for asynchronous pin inputs.
// Assumes: Pins are asynchronous to ref_clk.
// Notes:   A change is taken only once stages two and three agree.
`timescale 1ns/1ps
module hbp_pin_sync (
    input  wire logic                    ref_clk,
    input  wire logic                    srst,
    input  wire logic                    clk_en,
    input  wire logic [hbp_pkg::PIN_W-1:0] pins,
    output logic      [hbp_pkg::PIN_W-1:0] pins_stable
);
    logic [hbp_pkg::PIN_W-1:0] stage1;   // Read only by stage2.
    logic [hbp_pkg::PIN_W-1:0] stage2;   // Second flop.
    logic [hbp_pkg::PIN_W-1:0] stage3;   // Third flop.
    logic [hbp_pkg::PIN_W-1:0] next_stable;

    // Each bit follows only when the last two stages agree, filtering one-cycle glitches.
    always_comb begin
        for (int i = 0; i < hbp_pkg::PIN_W; i++) begin
            next_stable[i] = (stage2[i] == stage3[i]) ? stage3[i] : pins_stable[i];
        end
    end

    // Reset loads the idle level: strobes and enables high.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stage1      <= hbp_pkg::PIN_RST;
            stage2      <= hbp_pkg::PIN_RST;
            stage3      <= hbp_pkg::PIN_RST;
            pins_stable <= hbp_pkg::PIN_RST;
        end else if (clk_en) begin
            stage1      <= pins;
            stage2      <= stage1;
            stage3      <= stage2;
            pins_stable <= next_stable;
        end
    end
endmodule : hbp_pin_sync

// ==== verilog/hbp_host_port.sv ====
// Purpose: Host bus slave, link DMA handshake and interrupt pin.
// Assumes: Register file answers reg_rdata one cycle after reg_rd.
// Notes:   All pins are sampled through hbp_pin_sync, so timing is
//          in ref_clk cycles after the synchroniser delay.
`timescale 1ns/1ps
module hbp_host_port (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        clk_en,
    input  wire logic        dir_strobe_style,
    input  wire logic        mux_mode,
    input  wire logic        bus_8bit,
    input  wire logic        irq_open_drain,
    input  wire logic        irq_active_high,
    input  wire logic [7:0]  host_address_pins,
    input  wire logic [15:0] host_data_pins_in,
    input  wire logic        host_chip_select_n,
    input  wire logic        host_read_strobe_n,
    input  wire logic        host_write_strobe_n,
    input  wire logic        host_address_latch,
    input  wire logic        high_byte_enable_n,
    input  wire logic        low_byte_enable_n,
    input  wire logic        host_direction_line,
    input  wire logic        host_data_strobe_n,
    input  wire logic        transmit_message_end_n,
    output logic      [15:0] host_data_pins_out,
    output logic      [1:0]  host_data_oe_n,
    output logic      [7:0]  reg_addr,
    output logic             reg_rd,
    output logic             reg_wr,
    output logic      [1:0]  reg_lanes,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        irq_pending,
    output logic             irq_pin_out,
    output logic             irq_pin_oe_n,
    input  wire logic        rx_link_enable,
    input  wire logic        rx_dma_enable,
    input  wire logic        rx_fifo_not_empty,
    input  wire logic        rx_head_is_last,
    input  wire logic [1:0]  receiver_status_mode,
    input  wire logic [4:0]  rx_status_code,
    output logic             dma_receive_request_n,
    output logic             receive_message_end_n,
    input  wire logic        tx_link_enable,
    input  wire logic        tx_dma_enable,
    input  wire logic        tx_fifo_not_full,
    output logic             tx_push,
    output logic             tx_push_first,
    output logic             tx_close_frame,
    output logic             dma_transmit_request_n
);
    // Lane decode shared by address latch and live address paths.
    function automatic logic [1:0] lane_decode(input logic be_n, input logic a0, input logic narrow);
        logic [1:0] lanes;
        lanes = hbp_pkg::LANE_NONE;
        if (narrow)
            lanes = hbp_pkg::LANE_LOW;
        else
            case ({be_n, a0})
                2'h0:    lanes = hbp_pkg::LANE_WORD;
                2'h1:    lanes = hbp_pkg::LANE_HIGH;
                2'h2:    lanes = hbp_pkg::LANE_LOW;
                default: lanes = hbp_pkg::LANE_NONE;
            endcase
        return lanes;
    endfunction : lane_decode

    localparam logic [2:0] CNT_LOAD = 3'(hbp_pkg::ACCESS_CYC); // Access wait.

    logic [hbp_pkg::PIN_W-1:0] pin_vec;      // Raw pins gathered.
    logic [hbp_pkg::PIN_W-1:0] s;            // Synchronised pins.

    assign pin_vec = {transmit_message_end_n, host_data_strobe_n, host_direction_line,
                      low_byte_enable_n, high_byte_enable_n, host_address_latch,
                      host_write_strobe_n, host_read_strobe_n, host_chip_select_n,
                      host_data_pins_in, host_address_pins};

    hbp_pin_sync u_sync (
        .ref_clk     (ref_clk),
        .srst        (srst),
        .clk_en      (clk_en),
        .pins        (pin_vec),
        .pins_stable (s)
    );

    // Access decode; chip select is not required to toggle between cycles.
    logic cs_act;      // Chip select asserted.
    logic acc_rd;      // Read strobe phase active.
    logic acc_wr;      // Write strobe phase active.
    logic be_live;     // Byte enable for the selected style.
    assign cs_act  = !s[hbp_pkg::P_CS];
    assign acc_rd  = dir_strobe_style ? (cs_act && !s[hbp_pkg::P_DS] && s[hbp_pkg::P_DIR])
                                      : (cs_act && !s[hbp_pkg::P_RD]);
    assign acc_wr  = dir_strobe_style ? (cs_act && !s[hbp_pkg::P_DS] && !s[hbp_pkg::P_DIR])
                                      : (cs_act && !s[hbp_pkg::P_WR]);
    assign be_live = dir_strobe_style ? s[hbp_pkg::P_BLE] : s[hbp_pkg::P_BHE];

    // Address latch state: captured on the falling edge of the latch strobe.
    logic       ale_q, next_ale_q;       // Previous latch level.
    logic [7:0] lat_addr, next_lat_addr; // Latched address.
    logic       lat_be, next_lat_be;     // Latched byte enable.

    always_comb begin
        next_ale_q    = s[hbp_pkg::P_ALE];
        next_lat_addr = lat_addr;
        next_lat_be   = lat_be;
        if (ale_q && !s[hbp_pkg::P_ALE]) begin
            next_lat_addr = s[hbp_pkg::P_ADDR +: 8];
            next_lat_be   = be_live;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ale_q    <= 1'b1;
            lat_addr <= hbp_pkg::ADDR_RST;
            lat_be   <= 1'b1;
        end else if (clk_en) begin
            ale_q    <= next_ale_q;
            lat_addr <= next_lat_addr;
            lat_be   <= next_lat_be;
        end
    end

    // Demuxed mode uses the live pins, since the latch strobe just sits high.
    logic [7:0] eff_addr;   // Address for the new cycle.
    logic [1:0] eff_lanes;  // Lanes for the new cycle.
    assign eff_addr  = mux_mode ? lat_addr : s[hbp_pkg::P_ADDR +: 8];
    assign eff_lanes = lane_decode(mux_mode ? lat_be : be_live, eff_addr[0], bus_8bit);

    // Receive status byte built from mode and code fields.
    logic [7:0] status_byte;
    assign status_byte = {receiver_status_mode, 1'b0, rx_status_code};

    // Bus cycle state.
    hbp_pkg::hbp_bus_state_e state, next_state;
    logic [2:0]  cnt, next_cnt;                   // Access time counter.
    logic        rx_status_sel, next_rx_status_sel; // This read returns status byte.
    logic [15:0] next_data_out;
    logic [1:0]  next_oe_n;
    logic [7:0]  next_reg_addr;
    logic        next_reg_rd, next_reg_wr;
    logic [1:0]  next_reg_lanes;
    logic [15:0] next_reg_wdata;
    logic        next_tx_push, next_tx_first, next_tx_close;
    logic        tx_new_msg, next_tx_new_msg;     // Next push starts a message.
    logic        vec_read, next_vec_read;         // Vector register read seen.
    logic        status_read, next_status_read;   // Port status read seen.
    logic        rx_pop_last, next_rx_pop_last;   // Last byte of message popped.
    logic [15:0] rd_word;

    // Byte placement on read: in 8-bit mode the addressed byte goes on the low lines.
    assign rd_word = rx_status_sel ? {status_byte, status_byte} :
                     (bus_8bit && reg_addr[0]) ? {reg_rdata[15:8], reg_rdata[15:8]} : reg_rdata;

    // Bus cycle sequencing; strobe pulses last one cycle.
    always_comb begin
        next_state         = state;
        next_cnt           = cnt;
        next_rx_status_sel = rx_status_sel;
        next_data_out      = host_data_pins_out;
        next_oe_n          = host_data_oe_n;
        next_reg_addr      = reg_addr;
        next_reg_rd        = 1'b0;
        next_reg_wr        = 1'b0;
        next_reg_lanes     = reg_lanes;
        next_reg_wdata     = reg_wdata;
        next_tx_push       = 1'b0;
        next_tx_first      = 1'b0;
        next_tx_close      = 1'b0;
        next_tx_new_msg    = tx_new_msg;
        next_vec_read      = 1'b0;
        next_status_read   = 1'b0;
        next_rx_pop_last   = 1'b0;
        case (state)
            hbp_pkg::BUS_IDLE: begin
                if (acc_rd && eff_lanes != hbp_pkg::LANE_NONE) begin
                    next_reg_addr      = eff_addr;
                    next_reg_lanes     = eff_lanes;
                    next_reg_rd        = 1'b1;
                    next_cnt           = CNT_LOAD;
                    next_rx_status_sel = (eff_addr == hbp_pkg::LINK_RX_FIFO_ADDR) && rx_head_is_last;
                    next_rx_pop_last   = next_rx_status_sel;
                    next_vec_read      = (eff_addr == hbp_pkg::INT_VECTOR_ADDR);
                    next_status_read   = (eff_addr == hbp_pkg::LINK_STATUS_ADDR);
                    next_state         = hbp_pkg::BUS_READ_WAIT;
                end else if (acc_wr && eff_lanes != hbp_pkg::LANE_NONE) begin
                    next_reg_addr  = eff_addr;
                    next_reg_lanes = eff_lanes;
                    next_state     = hbp_pkg::BUS_WRITE_HOLD;
                end
            end
            hbp_pkg::BUS_READ_WAIT: begin
                // The host may withdraw early; then nothing is driven.
                if (!acc_rd) begin
                    next_state = hbp_pkg::BUS_IDLE;
                end else if (cnt <= 3'h1) begin
                    next_data_out = rd_word;
                    next_oe_n     = ~reg_lanes;
                    next_state    = hbp_pkg::BUS_READ_DRIVE;
                end else begin
                    next_cnt = cnt - 3'h1;
                end
            end
            hbp_pkg::BUS_READ_DRIVE: begin
                if (!acc_rd) begin
                    next_oe_n  = 2'h3;
                    next_state = hbp_pkg::BUS_IDLE;
                end
            end
            hbp_pkg::BUS_WRITE_HOLD: begin
                // Data is taken as the strobe goes away, from all lines (low byte doubled in 8-bit mode); reg_lanes marks the enabled lanes.
                if (!acc_wr) begin
                    next_reg_wr    = 1'b1;
                    next_reg_wdata = bus_8bit ? {2{s[hbp_pkg::P_DATA +: 8]}}
                                              : s[hbp_pkg::P_DATA +: 16];
                    if (reg_addr == hbp_pkg::LINK_TX_FIFO_ADDR) begin
                        next_tx_push    = 1'b1;
                        next_tx_first   = tx_new_msg;
                        next_tx_close   = !s[hbp_pkg::P_TRANSMIT_MESSAGE_END];
                        next_tx_new_msg = !s[hbp_pkg::P_TRANSMIT_MESSAGE_END];
                    end
                    next_state = hbp_pkg::BUS_IDLE;
                end
            end
            default: begin
                next_oe_n  = 2'h3;
                next_state = hbp_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state              <= hbp_pkg::BUS_IDLE;
            cnt                <= 3'h0;
            rx_status_sel      <= 1'b0;
            host_data_pins_out <= hbp_pkg::DATA_RST;
            host_data_oe_n     <= 2'h3;
            reg_addr           <= hbp_pkg::ADDR_RST;
            reg_rd             <= 1'b0;
            reg_wr             <= 1'b0;
            reg_lanes          <= hbp_pkg::LANE_NONE;
            reg_wdata          <= hbp_pkg::DATA_RST;
            tx_push            <= 1'b0;
            tx_push_first      <= 1'b0;
            tx_close_frame     <= 1'b0;
            tx_new_msg         <= 1'b1;
            vec_read           <= 1'b0;
            status_read        <= 1'b0;
            rx_pop_last        <= 1'b0;
        end else if (clk_en) begin
            state              <= next_state;
            cnt                <= next_cnt;
            rx_status_sel      <= next_rx_status_sel;
            host_data_pins_out <= next_data_out;
            host_data_oe_n     <= next_oe_n;
            reg_addr           <= next_reg_addr;
            reg_rd             <= next_reg_rd;
            reg_wr             <= next_reg_wr;
            reg_lanes          <= next_reg_lanes;
            reg_wdata          <= next_reg_wdata;
            tx_push            <= next_tx_push;
            tx_push_first      <= next_tx_first;
            tx_close_frame     <= next_tx_close;
            tx_new_msg         <= next_tx_new_msg;
            vec_read           <= next_vec_read;
            status_read        <= next_status_read;
            rx_pop_last        <= next_rx_pop_last;
        end
    end

    // Interrupt and DMA handshake state.
    logic irq_active, next_irq_active;   // Logical interrupt request.
    logic next_irq_out, next_irq_oe_n;
    logic next_drr_n, next_rme_n, next_drt_n;

    always_comb begin
        // A pending event always wins over the clear by a vector read.
        if (irq_pending)
            next_irq_active = 1'b1;
        else if (vec_read)
            next_irq_active = 1'b0;
        else
            next_irq_active = irq_active;
        // Open drain only pulls low; a high assertion then needs an external pull-up.
        if (irq_open_drain) begin
            next_irq_out  = 1'b0;
            next_irq_oe_n = (next_irq_active == irq_active_high);
        end else begin
            next_irq_out  = (next_irq_active == irq_active_high);
            next_irq_oe_n = 1'b0;
        end
        next_drr_n = !(rx_link_enable && rx_dma_enable && rx_fifo_not_empty);
        next_drt_n = !(tx_link_enable && tx_dma_enable && tx_fifo_not_full);
        // Message end set by the last pop beats a clear in the same cycle.
        if (rx_pop_last)
            next_rme_n = 1'b0;
        else if (status_read)
            next_rme_n = 1'b1;
        else
            next_rme_n = receive_message_end_n;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_active             <= 1'b0;
            irq_pin_out            <= 1'b0;
            irq_pin_oe_n           <= 1'b1;
            dma_receive_request_n  <= 1'b1;
            receive_message_end_n  <= 1'b1;
            dma_transmit_request_n <= 1'b1;
        end else if (clk_en) begin
            irq_active             <= next_irq_active;
            irq_pin_out            <= next_irq_out;
            irq_pin_oe_n           <= next_irq_oe_n;
            dma_receive_request_n  <= next_drr_n;
            receive_message_end_n  <= next_rme_n;
            dma_transmit_request_n <= next_drt_n;
        end
    end
endmodule : hbp_host_port

// ==== tb/hbp_port_asserts.sv ====
// Purpose: Pin-level timing checks for the host port.
// Assumes: clk_en is lowered only while the port is idle.
// Notes:   Bound to every hbp_host_port.
`timescale 1ns/1ps
module hbp_port_chk (
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic       rx_link_enable,
    input wire logic       rx_dma_enable,
    input wire logic       rx_fifo_not_empty,
    input wire logic       dma_receive_request_n,
    input wire logic       tx_link_enable,
    input wire logic       tx_dma_enable,
    input wire logic       tx_fifo_not_full,
    input wire logic       dma_transmit_request_n,
    input wire logic       reg_rd,
    input wire logic       reg_wr,
    input wire logic       tx_push,
    input wire logic       tx_push_first,
    input wire logic       tx_close_frame,
    input wire logic [1:0] host_data_oe_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_rx_req_on: assert property (rx_link_enable && rx_dma_enable && rx_fifo_not_empty |=> !dma_receive_request_n)
        else $error("rx request missing");
    a_rx_req_off: assert property (!rx_fifo_not_empty |=> dma_receive_request_n)
        else $error("rx request stuck");
    a_tx_req_on: assert property (tx_link_enable && tx_dma_enable && tx_fifo_not_full |-> ##[0:1] !dma_transmit_request_n)
        else $error("tx request missing");
    a_tx_req_off: assert property (!tx_fifo_not_full |-> ##[0:1] dma_transmit_request_n)
        else $error("tx request stuck");
    a_read_drive: assert property (reg_rd |-> ##2 host_data_oe_n != 2'h3)
        else $error("read data not driven");
    a_write_quiet: assert property (reg_wr |-> host_data_oe_n == 2'h3)
        else $error("lines driven in write");
    a_push_tags: assert property (tx_push_first || tx_close_frame |-> tx_push)
        else $error("tag without push");
    a_push_write: assert property (tx_push |-> reg_wr)
        else $error("push without write");
endmodule : hbp_port_chk
bind hbp_host_port hbp_port_chk u_hbp_port_chk (.*);

// ==== tb/hbp_cpu_model.sv ====
// Purpose: CPU and DMA side of the host pins.
// Assumes: Pins change at the falling edge.
// Notes:   Lanes nobody drives show the inverse of their last value.
`timescale 1ns/1ps
module hbp_cpu_model (
    input  wire logic        ref_clk,
    input  wire logic [15:0] host_data_pins_out,
    input  wire logic [1:0]  host_data_oe_n,
    output logic      [7:0]  host_address_pins = 8'h00,
    output logic      [15:0] host_data_pins_in,
    output logic             host_chip_select_n = 1'b1,
    output logic             host_read_strobe_n = 1'b1,
    output logic             host_write_strobe_n = 1'b1,
    output logic             host_address_latch = 1'b1,
    output logic             high_byte_enable_n = 1'b1,
    output logic             low_byte_enable_n = 1'b1,
    output logic             host_direction_line = 1'b1,
    output logic             host_data_strobe_n = 1'b1,
    output logic             transmit_message_end_n = 1'b1
);
    logic [15:0] cpu_d = 16'h0000; // Value the CPU side puts on the lines.
    // Each lane shows the device where it drives, else the CPU value.
    assign host_data_pins_in = {host_data_oe_n[1] ? cpu_d[15:8] : host_data_pins_out[15:8],
                                host_data_oe_n[0] ? cpu_d[7:0] : host_data_pins_out[7:0]};
    // One bus cycle; chip select stays low afterwards.
    task automatic cyc(input logic sty, input logic mux, input logic rd, input logic [7:0] a, input logic en_n,
                       input logic [15:0] wd, input logic tx_n, output logic [15:0] q, output logic seen);
        @(negedge ref_clk);
        host_address_pins = a;
        {high_byte_enable_n, low_byte_enable_n} = {2{en_n}};
        cpu_d = mux ? {~cpu_d[15:8], a} : ~cpu_d;
        if (mux) begin
            @(negedge ref_clk) host_address_latch = 1'b0;
            @(negedge ref_clk) host_address_pins = ~a;
        end
        @(negedge ref_clk) {host_chip_select_n, host_direction_line} = {1'b0, rd};
        @(negedge ref_clk) {cpu_d, transmit_message_end_n} = {rd ? ~cpu_d : wd, tx_n};
        if (sty) host_data_strobe_n = 1'b0;
        else if (rd) host_read_strobe_n = 1'b0;
        else host_write_strobe_n = 1'b0;
        seen = 1'b0;
        repeat (12) @(negedge ref_clk) seen |= (host_data_oe_n != 2'h3);
        q = host_data_pins_in;
        {host_data_strobe_n, host_read_strobe_n, host_write_strobe_n} = 3'h7;
        repeat (8) @(negedge ref_clk);
        {host_address_latch, transmit_message_end_n, cpu_d} = {2'h3, ~cpu_d};
    endtask : cyc
endmodule : hbp_cpu_model

// ==== tb/test_hbp_host_port.sv ====
// Purpose: Self-checking bench for the host port.
// Assumes: Register file answers one cycle after reg_rd.
// Notes:   Seeded random addresses and data, with corner cases.
`timescale 1ns/1ps
module test_hbp_host_port;
    logic ref_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, dir_strobe_style = 1'b0, mux_mode = 1'b0, bus_8bit = 1'b0;
    logic irq_open_drain = 1'b0, irq_active_high = 1'b0, irq_pending = 1'b0, irq_pin_out, irq_pin_oe_n;
    logic rx_link_enable = 1'b0, rx_dma_enable = 1'b0, rx_fifo_not_empty = 1'b0, rx_head_is_last = 1'b0;
    logic tx_link_enable = 1'b0, tx_dma_enable = 1'b0, tx_fifo_not_full = 1'b0, tx_push, tx_push_first;
    logic tx_close_frame, host_chip_select_n, host_read_strobe_n, host_write_strobe_n, host_address_latch;
    logic high_byte_enable_n, low_byte_enable_n, host_direction_line, host_data_strobe_n, transmit_message_end_n;
    logic reg_rd, reg_wr, dma_receive_request_n, receive_message_end_n, dma_transmit_request_n, seen, pf, pc;
    logic [1:0] receiver_status_mode = 2'h0, host_data_oe_n, reg_lanes, got_lanes, ln;
    logic [4:0] rx_status_code = 5'h00;
    logic [7:0] host_address_pins, reg_addr, a;
    logic [15:0] host_data_pins_in, host_data_pins_out, reg_wdata, reg_rdata = 16'h0000, q, wd, mem [256];
    logic [31:0] r;
    int seed, n_fail = 0, num_checks = 0;
    always #25 ref_clk = ~ref_clk;
    hbp_host_port u_hbp_host_port (.*);
    hbp_cpu_model u_hbp_cpu_model (.*);
    function automatic logic [15:0] msk(input logic [1:0] l);
        return {{8{l[1]}}, {8{l[0]}}};
    endfunction : msk
    // Register file behind the port; it also keeps the last lanes and push tags.
    always @(posedge ref_clk) begin
        if (reg_rd) reg_rdata <= mem[reg_addr];
        if (reg_wr) got_lanes <= reg_lanes;
        if (reg_wr) mem[reg_addr] <= (mem[reg_addr] & ~msk(reg_lanes)) | (reg_wdata & msk(reg_lanes));
        if (tx_push) {pf, pc} <= {tx_push_first, tx_close_frame};
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic bus(input logic rd, input logic [7:0] ad, input logic en_n, input logic tx_n);
        u_hbp_cpu_model.cyc(dir_strobe_style, mux_mode, rd, ad, en_n, wd, tx_n, q, seen);
    endtask : bus
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    // Cuts a hang short.
    initial begin
        #1000000;
        n_fail++;
        print_verdict();
    end
    initial begin
        seed = 29160;
        repeat (2) @(negedge ref_clk);
        srst = 1'b0;
        // All four bus styles with every lane code, the refused one last.
        for (int m = 0; m < 4; m++) begin
            {dir_strobe_style, mux_mode} = m[1:0];
            for (int c = 0; c < 4; c++) begin
                r = $random(seed);
                a = {1'b1, r[6:1], c[0]};
                wd = r[31:16];
                ln = {!c[1], !c[0]};
                bus(1'b0, a, c[1], 1'b1);
                if (c < 3) chk(got_lanes, ln, "lanes");
                bus(1'b1, a, c[1], 1'b1);
                chk(q & msk(ln), wd & msk(ln), "readback");
                chk(seen, c < 3, "drive");
                chk(host_data_oe_n, 2'h3, "release");
            end
        end
        // The odd byte of a word reaches the low lines in 8-bit mode.
        {dir_strobe_style, mux_mode, bus_8bit} = 3'h0;
        bus(1'b0, 8'h87, 1'b0, 1'b1);
        bus_8bit = 1'b1;
        bus(1'b0, 8'h86, 1'b0, 1'b1);
        chk(got_lanes, 2'h1, "narrow lanes");
        bus(1'b1, 8'h86, 1'b0, 1'b1);
        chk(q[7:0], wd[7:0], "narrow read");
        bus(1'b1, 8'h87, 1'b0, 1'b1);
        chk(q[7:0], wd[15:8], "narrow odd read");
        bus_8bit = 1'b0;
        {rx_link_enable, rx_dma_enable, rx_fifo_not_empty, rx_head_is_last} = 4'hf;
        {receiver_status_mode, rx_status_code} = r[6:0];
        repeat (3) @(negedge ref_clk);
        chk(dma_receive_request_n, 1'b0, "rx request");
        bus(1'b1, 8'h40, 1'b0, 1'b1);
        chk(q, {2{r[6:5], 1'b0, r[4:0]}}, "status byte");
        chk(receive_message_end_n, 1'b0, "message end");
        {rx_fifo_not_empty, rx_head_is_last} = 2'h0;
        bus(1'b1, 8'h44, 1'b0, 1'b1);
        chk(receive_message_end_n, 1'b1, "end cleared");
        chk(dma_receive_request_n, 1'b1, "rx idle");
        {tx_link_enable, tx_dma_enable, tx_fifo_not_full} = 3'h7;
        bus(1'b0, 8'h42, 1'b0, 1'b0);
        chk({pf, pc}, 2'h3, "close");
        chk(dma_transmit_request_n, 1'b0, "tx request");
        bus(1'b0, 8'h42, 1'b0, 1'b1);
        chk({pf, pc}, 2'h2, "new message");
        tx_fifo_not_full = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(dma_transmit_request_n, 1'b1, "tx full");
        // A frozen clock enable must hold the idle pin although an event arrives.
        clk_en = 1'b0;
        irq_pending = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk({irq_pin_oe_n, irq_pin_out}, 2'h1, "frozen irq");
        clk_en = 1'b1;
        // Every pin style while an event is pending, ending push-pull active low.
        irq_pending = 1'b1;
        for (int k = 3; k >= 0; k--) begin
            {irq_open_drain, irq_active_high} = k[1:0];
            repeat (3) @(negedge ref_clk);
            chk({irq_pin_oe_n, irq_pin_out}, {k[1] & k[0], !k[1] & k[0]}, "irq level");
        end
        bus(1'b1, 8'h00, 1'b0, 1'b1);
        chk({irq_pin_oe_n, irq_pin_out}, 2'h0, "irq held");
        irq_pending = 1'b0;
        bus(1'b1, 8'h00, 1'b0, 1'b1);
        chk({irq_pin_oe_n, irq_pin_out}, 2'h1, "irq cleared");
        print_verdict();
    end
endmodule : test_hbp_host_port
